// ===== pkg/vmrr_pkg.sv
package vmrr_pkg;
   // -------------------------------------------------------------
   // channel counts and slot layout
   // -------------------------------------------------------------
   localparam int NUM_VOLT = 13;          // voltage channels
   localparam int NUM_TEMP = 4;           // local plus three remote
   localparam int NUM_SLOT = NUM_TEMP + NUM_VOLT;
   localparam logic [4:0] SLOT_LOCAL = 5'h00;
   localparam logic [4:0] SLOT_LAST  = 5'h10;
   localparam logic [4:0] SLOT_BATT  = 5'h0e;  // pin 26 slot
   localparam int ADC_BITS = 10;
   localparam int AVG_SAMPLES = 16;
   localparam logic [4:0] AVG_LAST = 5'h0f;

   // -------------------------------------------------------------
   // timing, clock at 10 MHz
   // -------------------------------------------------------------
   localparam real CLK_PERIOD_NS = 100.0;
   localparam real LOCAL_TIME_MS  = 9.01;
   localparam real REMOTE_TIME_MS = 38.36;
   localparam real VOLT_TIME_MS   = 8.53;
   localparam real BATT_TIME_US   = 711.0;
   localparam int LOCAL_CYC  = $rtoi(LOCAL_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int REMOTE_CYC = $rtoi(REMOTE_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int VOLT_CYC   = $rtoi(VOLT_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int BATT_CYC   = $rtoi(BATT_TIME_US * 1.0e3 / CLK_PERIOD_NS);

   // -------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_PINCFG0 = 8'h10;
   localparam logic [7:0] ADDR_PINCFG1 = 8'h11;
   localparam logic [7:0] ADDR_PINCFG2 = 8'h12;
   localparam logic [7:0] ADDR_PINCFG3 = 8'h13;
   localparam logic [7:0] ADDR_ATTEN0  = 8'h18;
   localparam logic [7:0] ADDR_ATTEN1  = 8'h19;
   localparam logic [7:0] ADDR_STAT0   = 8'hb8;
   localparam logic [7:0] ADDR_STAT1   = 8'hb9;
   localparam logic [7:0] ADDR_MASK0   = 8'hc0;
   localparam logic [7:0] ADDR_MASK1   = 8'hc1;
   localparam logic [7:0] RST_PINCFG0  = 8'hff;
   localparam logic [7:0] RST_PINCFG1  = 8'h1f;
   localparam logic [7:0] RST_PINCFG2  = 8'h0f;
   localparam logic [7:0] RST_PINCFG3  = 8'h00;
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam int BATT_MODE_BIT = 0;      // pinconfig3: pin 26 is battery

   // -------------------------------------------------------------
   // per voltage channel: pins 7,8,13,15,19,21,22,23,24,25,26,28,29
   // -------------------------------------------------------------
   typedef logic [7:0] vmrr_byte_t;
   localparam vmrr_byte_t VALUE_ADDR [NUM_VOLT] = '{8'ha3, 8'ha5, 8'h96,
      8'h8b, 8'h8f, 8'ha7, 8'ha9, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95};
   localparam vmrr_byte_t LOW_ADDR [NUM_VOLT] = '{8'h6d, 8'h6e, 8'h70,
      8'h45, 8'h47, 8'h71, 8'h6f, 8'h72, 8'h73, 8'h74, 8'h75, 8'h77, 8'h76};
   localparam vmrr_byte_t HIGH_ADDR [NUM_VOLT] = '{8'h7c, 8'h7d, 8'h68,
      8'h49, 8'h4b, 8'h7e, 8'h7f, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h50, 8'h4c};
   localparam vmrr_byte_t LOW_RST [NUM_VOLT] = '{8'h00, 8'h00, 8'h00,
      8'h40, 8'h40, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
   localparam vmrr_byte_t HIGH_RST [NUM_VOLT] = '{8'hff, 8'hff, 8'hff,
      8'h95, 8'h95, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'ha4, 8'ha4};

   // -------------------------------------------------------------
   // sequencer states, gray along seek, convert, store
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_SEEK  = 2'b00,
      ST_CONV  = 2'b01,
      ST_STORE = 2'b11
   } vmrr_state_t;
endpackage

// ===== rtl/vmrr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module vmrr_monitor #(
   parameter int LOCAL_CYC  = vmrr_pkg::LOCAL_CYC,
   parameter int REMOTE_CYC = vmrr_pkg::REMOTE_CYC,
   parameter int VOLT_CYC   = vmrr_pkg::VOLT_CYC,
   parameter int BATT_CYC   = vmrr_pkg::BATT_CYC
) (
   input  wire logic                           clk_in,        // 10 MHz
   input  wire logic                           reset_in,      // async high
   input  wire logic [7:0]                     reg_addr_in,   // reg address
   input  wire logic                           reg_wr_in,     // write strobe
   input  wire logic [7:0]                     reg_wdata_in,  // write data
   input  wire logic                           reg_rd_in,     // read strobe
   output logic      [7:0]                     reg_rdata_out, // read data
   input  wire logic [vmrr_pkg::ADC_BITS-1:0]  adc_data_in,   // ADC result
   output logic                                adc_start_out, // start pulse
   output logic      [4:0]                     adc_chan_out,  // mux select
   output logic                                batt_div_on_out, // divider
   output logic [vmrr_pkg::NUM_VOLT-1:0]       atten_bypass_out, // bypass
   output logic                                alert_n_out    // alert, low
);
   import vmrr_pkg::*;

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   vmrr_state_t                state_q;
   logic [4:0]                 slot_q;
   logic [4:0]                 slot_next;
   logic [19:0]                sub_q;
   logic [19:0]                per_c;
   logic [4:0]                 samp_q;
   logic [13:0]                acc_q;
   logic [13:0]                acc_d;
   logic                       sub_last;
   logic                       samp_last;
   logic                       batt_slot;
   logic                       batt_sel;
   logic                       batt_q;
   logic [NUM_SLOT-1:0]        en_vec;
   logic [7:0]                 pincfg_q [4];
   logic [7:0]                 atten_q [2];
   logic [15:0]                mask_q;
   logic [NUM_VOLT-1:0]        status_q;
   logic [7:0]                 value_q [NUM_VOLT];
   logic [7:0]                 low_q [NUM_VOLT];
   logic [7:0]                 high_q [NUM_VOLT];
   logic [7:0]                 result_c;
   logic [7:0]                 rdata_c;
   logic [3:0]                 vidx;
   logic                       vstore;

   // -------------------------------------------------------------
   // channel enables from the pin configuration
   // -------------------------------------------------------------
   // slots hold only ADC inputs; fan speed never gets one
   assign en_vec = {pincfg_q[1][4:0], pincfg_q[0],
                    pincfg_q[2][3:0]};
   // battery mode is latched at slot entry, so a config write cannot
   // change timing or scaling in the middle of a conversion
   assign batt_sel  = (slot_q == SLOT_BATT) && pincfg_q[3][BATT_MODE_BIT];
   assign batt_slot = (state_q == ST_SEEK) ? batt_sel : batt_q;
   assign slot_next = (slot_q == SLOT_LAST) ? SLOT_LOCAL : slot_q + 5'h01;
   assign vidx = 4'(slot_q - 5'(NUM_TEMP));
   assign vstore = (state_q == ST_STORE) && (slot_q >= 5'(NUM_TEMP));

   // sample period per slot type
   always_comb begin
      if (batt_slot) begin
         per_c = 20'(BATT_CYC);
      end else if (slot_q == SLOT_LOCAL) begin
         per_c = 20'(LOCAL_CYC / AVG_SAMPLES);
      end else if (slot_q < 5'(NUM_TEMP)) begin
         per_c = 20'(REMOTE_CYC / AVG_SAMPLES);
      end else begin
         per_c = 20'(VOLT_CYC / AVG_SAMPLES);
      end
   end

   assign sub_last  = (sub_q == per_c - 20'h00001);
   assign samp_last = batt_slot || (samp_q == AVG_LAST);
   assign acc_d     = acc_q + 14'(adc_data_in);

   // -------------------------------------------------------------
   // round robin sequencer
   // -------------------------------------------------------------
   // seek skips disabled slots, convert runs the samples, store writes
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= ST_SEEK;
         slot_q  <= SLOT_LOCAL;
      end else begin
         unique case (state_q)
            ST_SEEK: begin
               if (en_vec[slot_q]) begin
                  state_q <= ST_CONV;
               end else begin
                  slot_q <= slot_next;
               end
            end
            ST_CONV: begin
               if (sub_last && samp_last) begin
                  state_q <= ST_STORE;
               end
            end
            ST_STORE: begin
               state_q <= ST_SEEK;
               slot_q  <= slot_next;
            end
         endcase
      end
   end

   // battery mode held for the whole conversion of the slot
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         batt_q <= 1'b0;
      end else if (state_q == ST_SEEK) begin
         batt_q <= batt_sel;
      end
   end

   // sample timer and sample counter inside one conversion
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sub_q  <= 20'h00000;
         samp_q <= 5'h00;
      end else if (state_q != ST_CONV) begin
         sub_q  <= 20'h00000;
         samp_q <= 5'h00;
      end else if (sub_last) begin
         sub_q  <= 20'h00000;
         samp_q <= samp_q + 5'h01;
      end else begin
         sub_q <= sub_q + 20'h00001;
      end
   end

   // accumulate ADC results at the end of each sample period
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         acc_q <= 14'h0000;
      end else if (state_q == ST_SEEK) begin
         acc_q <= 14'h0000;
      end else if (state_q == ST_CONV && sub_last) begin
         acc_q <= acc_d;
      end
   end

   // averaged ten-bit result, upper eight bits kept
   always_comb begin
      if (batt_slot) begin
         result_c = acc_q[9:2];
      end else begin
         result_c = acc_q[13:6];
      end
   end

   // ADC control outputs
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         adc_start_out <= 1'b0;
         adc_chan_out  <= SLOT_LOCAL;
      end else begin
         adc_start_out <= (state_q == ST_SEEK && en_vec[slot_q]) ||
                          (state_q == ST_CONV && sub_last && !samp_last);
         adc_chan_out  <= slot_q;
      end
   end

   // battery divider lower leg only during the battery window
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         batt_div_on_out <= 1'b0;
      end else if (state_q == ST_SEEK && en_vec[slot_q] && batt_slot) begin
         batt_div_on_out <= 1'b1;
      end else if (state_q == ST_CONV && sub_last) begin
         batt_div_on_out <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // configuration and mask registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pincfg_q[0] <= RST_PINCFG0;
         pincfg_q[1] <= RST_PINCFG1;
         pincfg_q[2] <= RST_PINCFG2;
         pincfg_q[3] <= RST_PINCFG3;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            ADDR_PINCFG0: pincfg_q[0] <= reg_wdata_in;
            ADDR_PINCFG1: pincfg_q[1] <= reg_wdata_in;
            ADDR_PINCFG2: pincfg_q[2] <= reg_wdata_in;
            ADDR_PINCFG3: pincfg_q[3] <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         atten_q[0] <= RST_ZERO;
         atten_q[1] <= RST_ZERO;
         mask_q     <= 16'h0000;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            ADDR_ATTEN0: atten_q[0] <= reg_wdata_in;
            ADDR_ATTEN1: atten_q[1] <= reg_wdata_in;
            ADDR_MASK0:  mask_q[7:0]  <= reg_wdata_in;
            ADDR_MASK1:  mask_q[15:8] <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // attenuator bypass drive
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         atten_bypass_out <= '0;
      end else begin
         atten_bypass_out <= {atten_q[1][4:0], atten_q[0]};
      end
   end

   // -------------------------------------------------------------
   // per channel value, limit and status registers
   // -------------------------------------------------------------
   for (genvar v = 0; v < NUM_VOLT; v++) begin : g_chan
      // limits written by software
      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            low_q[v]  <= LOW_RST[v];
            high_q[v] <= HIGH_RST[v];
         end else if (reg_wr_in) begin
            if (reg_addr_in == LOW_ADDR[v]) begin
               low_q[v] <= reg_wdata_in;
            end
            if (reg_addr_in == HIGH_ADDR[v]) begin
               high_q[v] <= reg_wdata_in;
            end
         end
      end

      // value and status written together at store
      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            value_q[v]  <= RST_ZERO;
            status_q[v] <= 1'b0;
         end else if (vstore && vidx == 4'(v)) begin
            value_q[v]  <= result_c;
            status_q[v] <= (result_c < low_q[v]) ||
                           (result_c > high_q[v]);
         end
      end
   end

   // -------------------------------------------------------------
   // alert and read port
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         alert_n_out <= 1'b1;
      end else begin
         alert_n_out <= ~|(status_q & ~mask_q[NUM_VOLT-1:0]);
      end
   end

   // read decode, unmapped reads return zero
   always_comb begin
      rdata_c = RST_ZERO;
      unique case (reg_addr_in)
         ADDR_PINCFG0: rdata_c = pincfg_q[0];
         ADDR_PINCFG1: rdata_c = pincfg_q[1];
         ADDR_PINCFG2: rdata_c = pincfg_q[2];
         ADDR_PINCFG3: rdata_c = pincfg_q[3];
         ADDR_ATTEN0:  rdata_c = atten_q[0];
         ADDR_ATTEN1:  rdata_c = atten_q[1];
         ADDR_STAT0:   rdata_c = status_q[7:0];
         ADDR_STAT1:   rdata_c = {3'h0, status_q[12:8]};
         ADDR_MASK0:   rdata_c = mask_q[7:0];
         ADDR_MASK1:   rdata_c = mask_q[15:8];
         default: ;
      endcase
      for (int i = 0; i < NUM_VOLT; i++) begin
         if (reg_addr_in == VALUE_ADDR[i]) begin
            rdata_c = value_q[i];
         end
         if (reg_addr_in == LOW_ADDR[i]) begin
            rdata_c = low_q[i];
         end
         if (reg_addr_in == HIGH_ADDR[i]) begin
            rdata_c = high_q[i];
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= RST_ZERO;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_c;
      end
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   logic [19:0] batt_on_cnt_q;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         batt_on_cnt_q <= 20'h00000;
      end else if (batt_div_on_out) begin
         batt_on_cnt_q <= batt_on_cnt_q + 20'h00001;
      end else begin
         batt_on_cnt_q <= 20'h00000;
      end
   end

   sequence s_store_done;
      state_q == ST_STORE ##1 state_q == ST_SEEK;
   endsequence

   // enables may change mid conversion, so they are judged at seek;
   // limits are those held in the store cycle, not after it
   a_store_then_seek: assert property (
      state_q == ST_STORE |-> s_store_done)
      else $error("store not followed by seek");
   a_conv_enabled: assert property (
      state_q == ST_SEEK |=>
         (state_q == ST_CONV) == $past(en_vec[slot_q]))
      else $error("slot enable not followed");
   a_samples_bound: assert property (
      state_q == ST_CONV |-> samp_q <= AVG_LAST)
      else $error("sample count over sixteen");
   a_batt_single: assert property (
      state_q == ST_CONV && batt_slot |-> samp_q == 5'h00)
      else $error("battery sampled more than once");
   a_div_only_batt: assert property (
      batt_div_on_out |-> batt_slot && state_q != ST_SEEK)
      else $error("divider on outside battery slot");
   a_div_window: assert property (
      $fell(batt_div_on_out) |-> batt_on_cnt_q == 20'(BATT_CYC))
      else $error("battery window length wrong");
   a_status_cmp: assert property (
      vstore |=> status_q[$past(vidx)] ==
         ((value_q[$past(vidx)] < $past(low_q[vidx])) ||
          (value_q[$past(vidx)] > $past(high_q[vidx]))))
      else $error("status not matching limits");
   a_alert_follow: assert property (
      |(status_q & ~mask_q[NUM_VOLT-1:0]) |=> !alert_n_out)
      else $error("alert missing for set status");
   a_alert_quiet: assert property (
      !(|(status_q & ~mask_q[NUM_VOLT-1:0])) |=> alert_n_out)
      else $error("alert without set status");
endmodule
`default_nettype wire

// ===== testbench/vmrr_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module vmrr_adc_model (
   input  wire logic       clk_in,       // bench clock
   input  wire logic       start_in,     // sample start pulse
   input  wire logic [4:0] chan_in,      // mux select
   input  wire logic [9:0] code_in [17], // base code per slot
   output logic      [9:0] data_out      // converted sample
);
   logic [4:0] last_q = 5'h1f;
   logic [3:0] idx_q  = 4'h0;
   logic [7:0] age_q  = 8'h00;
   // sample index within a slot, age since the last start
   always @(posedge clk_in) begin
      if (start_in) begin
         idx_q  <= (chan_in == last_q) ? idx_q + 4'h1 : 4'h0;
         last_q <= chan_in;
         age_q  <= 8'h00;
      end else if (age_q != 8'hff) begin
         age_q <= age_q + 8'h01;
      end
   end
   // toggling junk while settling, then base plus index
   assign data_out = (age_q < 8'h02) ? (10'h2aa ^ {10{age_q[0]}})
                   : code_in[last_q] + {6'h00, idx_q};
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import vmrr_pkg::*;
   localparam int LC = 160;
   localparam int RC = 320;
   localparam int VC = 160;
   localparam int BC = 20;
   logic                clk_in       = 1'b0;
   logic                reset_in     = 1'b1;
   logic [7:0]          reg_addr_in  = 8'h00;
   logic                reg_wr_in    = 1'b0;
   logic [7:0]          reg_wdata_in = 8'h00;
   logic                reg_rd_in    = 1'b0;
   logic [7:0]          reg_rdata_out;
   logic [9:0]          adc_data_in;
   logic                adc_start_out;
   logic [4:0]          adc_chan_out;
   logic                batt_div_on_out;
   logic [NUM_VOLT-1:0] atten_bypass_out;
   logic                alert_n_out;
   logic [9:0]          codes [17];
   logic [15:0]         exp_q [$];
   logic [4:0]          chan_q [$];
   logic [4:0]          prev_q = 5'h1f;
   logic [12:0]         stat;
   logic                rd_q, rd_qq, batt, steady, order_on;
   int                  mismatches, checks, gap, nsamp, dcnt;

   vmrr_monitor #(.LOCAL_CYC(LC), .REMOTE_CYC(RC), .VOLT_CYC(VC),
      .BATT_CYC(BC)) dut (.clk_in(clk_in), .reset_in(reset_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .adc_data_in(adc_data_in),
      .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out),
      .batt_div_on_out(batt_div_on_out),
      .atten_bypass_out(atten_bypass_out), .alert_n_out(alert_n_out));
   vmrr_adc_model adc (.clk_in(clk_in), .start_in(adc_start_out),
      .chan_in(adc_chan_out), .code_in(codes), .data_out(adc_data_in));

   // free-running clock
   initial begin
      forever #50 clk_in = ~clk_in;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
      checks++;
      if (e !== g) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      exp_q.push_back({a, e});
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      @(negedge clk_in);
   endtask

   task automatic wait_start(input logic [4:0] c);
      int i;
      logic [4:0] lc;
      // only the first sample of a new conversion on slot c counts
      lc = adc_chan_out;
      for (i = 0; i < 40000; i++) begin
         @(posedge clk_in);
         if (adc_start_out === 1'b1 && adc_chan_out === c &&
             lc !== c) break;
         if (adc_start_out === 1'b1) lc = adc_chan_out;
      end
      if (i == 40000) begin
         mismatches++;
         end_of_test();
      end
   endtask

   // compares read data once it has settled
   always @(negedge clk_in) begin
      if (rd_qq === 1'b1 && exp_q.size() > 0) begin
         check($sformatf("reg %h", exp_q[0][15:8]), {8'h00, exp_q[0][7:0]},
               {8'h00, reg_rdata_out});
         void'(exp_q.pop_front());
      end
   end

   // watches sequencer timing, order and divider
   always @(posedge clk_in) begin
      rd_qq <= rd_q;
      rd_q <= reg_rd_in;
      if (batt_div_on_out === 1'b1) begin
         dcnt++;
      end else if (dcnt != 0) begin
         check("divider time", 16'(BC), 16'(dcnt));
         dcnt = 0;
      end
      if (adc_start_out === 1'b1) begin
         if (adc_chan_out !== SLOT_BATT || !batt)
            check("divider off", 16'h0, {15'h0, batt_div_on_out});
         if (adc_chan_out === prev_q) begin
            check("period", 16'((prev_q == 5'h0) ? LC / 16 :
               (prev_q < 5'h4) ? RC / 16 : VC / 16), 16'(gap));
            nsamp++;
         end else begin
            if (steady) check("samples", (batt && prev_q == SLOT_BATT) ?
               16'h1 : 16'h10, 16'(nsamp));
            if (order_on && chan_q.size() > 0) begin
               check("slot", {11'h0, chan_q[0]},
                     {11'h0, adc_chan_out});
               void'(chan_q.pop_front());
            end
            nsamp = 1;
         end
         prev_q = adc_chan_out;
         gap = 1;
      end else begin
         gap++;
      end
   end

   task automatic verify(input logic bm);
      logic [13:0] s;
      logic [7:0]  lo;
      logic [7:0]  hi;
      logic [7:0]  ev [NUM_VOLT];
      steady = 1'b0;
      batt = bm;
      wr(ADDR_PINCFG0, 8'hff);
      wr(ADDR_PINCFG1, 8'h1f);
      wr(ADDR_PINCFG2, 8'h00);
      wr(ADDR_PINCFG3, {7'h0, bm});
      for (int v = 0; v < NUM_VOLT; v++) begin
         lo = (v == 0) ? 8'hff : 8'($urandom);
         hi = 8'($urandom);
         wr(LOW_ADDR[v], lo);
         wr(HIGH_ADDR[v], hi);
         codes[v + 4] = 10'($urandom % 1000);
         s = {codes[v + 4], 4'h0} + 14'h0078;
         ev[v] = (bm && v == 10) ? codes[v + 4][9:2] : s[13:6];
         stat[v] = (ev[v] < lo) || (ev[v] > hi);
      end
      wait_start(5'h04);
      @(negedge clk_in);
      steady = 1'b1;
      wait_start(5'h04);
      for (int v = 0; v < NUM_VOLT; v++) begin
         wr(VALUE_ADDR[v], ~ev[v]);
         rd(VALUE_ADDR[v], ev[v]);
      end
      rd(ADDR_STAT0, stat[7:0]);
      rd(ADDR_STAT1, {3'h0, stat[12:8]});
   endtask

   // main sequence
   initial begin
      logic [7:0] r;
      {rd_q, rd_qq, batt, steady, order_on} = 5'h00;
      {mismatches, checks, gap, nsamp, dcnt} = '0;
      void'($urandom(32'h72e2));
      for (int s = 0; s < 17; s++) codes[s] = 10'h300;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      reset_in = 1'b0;
      for (int i = 0; i < NUM_VOLT; i++) begin
         rd(LOW_ADDR[i], LOW_RST[i]);
         rd(HIGH_ADDR[i], HIGH_RST[i]);
      end
      rd(ADDR_PINCFG0, RST_PINCFG0);
      rd(ADDR_PINCFG1, RST_PINCFG1);
      rd(ADDR_PINCFG2, RST_PINCFG2);
      rd(ADDR_PINCFG3, RST_PINCFG3);
      rd(8'h3f, 8'h00);
      wr(ADDR_PINCFG2, 8'h05);
      wr(ADDR_PINCFG0, 8'h81);
      wr(ADDR_PINCFG1, 8'h10);
      wait_start(5'h02);
      wait_start(5'h00);
      @(negedge clk_in);
      steady = 1'b1;
      chan_q = '{5'h02, 5'h04, 5'h0b, 5'h10, 5'h00};
      order_on = 1'b1;
      wait_start(5'h02);
      wait_start(5'h00);
      @(negedge clk_in);
      order_on = 1'b0;
      check("slots left", 16'h0, 16'(chan_q.size()));
      verify(1'b0);
      wr(ADDR_MASK0, 8'hff);
      wr(ADDR_MASK1, 8'h1f);
      repeat (3) @(negedge clk_in);
      check("alert masked", 16'h1, {15'h0, alert_n_out});
      wr(ADDR_MASK0, 8'hfe);
      repeat (3) @(negedge clk_in);
      check("alert", 16'h0, {15'h0, alert_n_out});
      r = 8'($urandom);
      wr(ADDR_ATTEN0, r);
      wr(ADDR_ATTEN1, ~r);
      @(negedge clk_in);
      check("bypass", {3'h0, ~r[4:0], r},
            {3'h0, atten_bypass_out});
      rd(ADDR_ATTEN0, r);
      verify(1'b1);
      end_of_test();
   end
endmodule
`default_nettype wire
